// ---- logic/trc_regs.svh ----
// register offsets, field positions, reset values and divider counts of the timer
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH

`define TRC_OFS_CTRL 5'h00
`define TRC_OFS_CSRC 5'h04
`define TRC_OFS_CNT_LO 5'h08
`define TRC_OFS_CNT_HI 5'h0C
`define TRC_OFS_RLD_LO 5'h10
`define TRC_OFS_RLD_HI 5'h14
`define TRC_OFS_IE 5'h18

`define TRC_CTL_OVF 7
`define TRC_CTL_EXT 6
`define TRC_CTL_RUN 1
`define TRC_CTL_EXEN 0

`define TRC_CTL_RST 6'h00
`define TRC_CSRC_RST 2'h0
`define TRC_CNT_RST 16'h0000
`define TRC_CNT_MAX 16'hFFFF

`define TRC_DIV_1 9'h001
`define TRC_DIV_8 9'h008
`define TRC_DIV_64 9'h040
`define TRC_DIV_256 9'h100

`endif

// ---- logic/trc_pkg.sv ----
// shared types of the reload/capture timer
package trc_pkg;
  typedef enum logic [1:0] {
    mode_reload,
    mode_baud,
    mode_cap_rise,
    mode_cap_fall
  } trc_mode_t;
endpackage

// ---- logic/trc_edge_sync.sv ----
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module trc_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic [2:0] arm_q;

  // edges held off until the flops have seen the pin, so reset gives no false edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 3'h0;
    end else begin
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = arm_q[2] & sync_q & ~prev_q;
  assign fall = arm_q[2] & ~sync_q & prev_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  edge_once_a: assert property (rise |=> !rise) else $error("edge acted twice");
endmodule

// ---- logic/trc_prescale.sv ----
// count clock prescaler: one tick every 1, 8, 64 or 256 system clocks
`timescale 1ns/10ps
`include "trc_regs.svh"
module trc_prescale #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [CNT_W-1:0] div_q;
  logic [8:0] lim;

  if (CNT_W < 8) begin : g_chk
    $error("prescaler counter too narrow for divide by 256");
  end

  always_comb begin
    unique case (sel)
      2'h0: lim = `TRC_DIV_1 - 9'h001;
      2'h1: lim = `TRC_DIV_8 - 9'h001;
      2'h2: lim = `TRC_DIV_64 - 9'h001;
      2'h3: lim = `TRC_DIV_256 - 9'h001;
    endcase
  end

  assign tick = run & (9'(div_q) >= lim);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (!run || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ps_div8_a: assert property ((tick && run && sel == 2'h1) ##1 (run && sel == 2'h1)[*8]
    |-> tick && $past(!tick)) else $error("divide by 8 spacing wrong");
  ps_div1_a: assert property (run && sel == 2'h0 |-> tick) else $error("divide by 1 no tick");
endmodule

// ---- logic/trc_timer.sv ----
// 16-bit reload/capture timer with prescaler and Avalon-MM register slave
// Operation
// - reload mode wrap sets overflow, reloads count
// - reload mode: overflow or edge reloads, flags
// - interrupt enable passes both flags to request
// - starting run keeps current count value
// - baud mode reloads on wrap, no interrupt
// - baud mode edge sets flag, no reload
// - baud rate from prescaled clock and reload
// - capture modes free run, wrap to zero
// - capture edge copies count, sets event flag
// - overflow flag hardware set, software clears
// - event flag only with trigger enable
// - prescale field divides by 1/8/64/256
// - mode field picks one of four modes
// - trigger enable off ignores all edges
// - source field picks pin, rc, receivers
// - capture config upper six bits read-only zero
// - count bytes reset zero, read/write
// - reload bytes reset zero, read/write
`timescale 1ns/10ps
`include "trc_regs.svh"
module trc_timer #(
  parameter int ADDR_W = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_input_pin,
  input wire logic lirc_clock,
  input wire logic first_serial_receive_pin,
  input wire logic second_serial_receive_pin,
  output logic timer_irq,
  output logic baud_tick
);
  if (ADDR_W != 5) begin : g_chk
    $error("address width must be 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic ack_q;
  logic req;
  logic wr_go;
  logic [7:0] wd;
  logic [7:0] rd_mux;
  logic [31:0] rdata_q;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go = avs_write & ack_q & avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  assign avs_readdata = rdata_q;

  // one wait state on every access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  logic wr_ctl;
  logic wr_csrc;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_ie;

  assign wr_ctl = wr_go & (avs_address == `TRC_OFS_CTRL);
  assign wr_csrc = wr_go & (avs_address == `TRC_OFS_CSRC);
  assign wr_cnt_lo = wr_go & (avs_address == `TRC_OFS_CNT_LO);
  assign wr_cnt_hi = wr_go & (avs_address == `TRC_OFS_CNT_HI);
  assign wr_rld_lo = wr_go & (avs_address == `TRC_OFS_RLD_LO);
  assign wr_rld_hi = wr_go & (avs_address == `TRC_OFS_RLD_HI);
  assign wr_ie = wr_go & (avs_address == `TRC_OFS_IE);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [5:0] ctl_q;
  logic [1:0] csrc_q;
  logic ie_q;
  logic ovf_q;
  logic ext_q;
  logic [15:0] cnt_q;
  logic [15:0] rld_q;
  trc_pkg::trc_mode_t mode;
  logic run;
  logic exen;

  assign mode = trc_pkg::trc_mode_t'(ctl_q[3:2]);
  assign run = ctl_q[`TRC_CTL_RUN];
  assign exen = ctl_q[`TRC_CTL_EXEN];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= `TRC_CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= wd[5:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csrc_q <= `TRC_CSRC_RST;
    end else if (wr_csrc) begin
      csrc_q <= wd[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= 1'b0;
    end else if (wr_ie) begin
      ie_q <= wd[0];
    end
  end

  always_comb begin
    unique case (avs_address)
      `TRC_OFS_CTRL: rd_mux = {ovf_q, ext_q, ctl_q};
      `TRC_OFS_CSRC: rd_mux = {6'h00, csrc_q};
      `TRC_OFS_CNT_LO: rd_mux = cnt_q[7:0];
      `TRC_OFS_CNT_HI: rd_mux = cnt_q[15:8];
      `TRC_OFS_RLD_LO: rd_mux = rld_q[7:0];
      `TRC_OFS_RLD_HI: rd_mux = rld_q[15:8];
      `TRC_OFS_IE: rd_mux = {7'h00, ie_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data is caught on the first cycle of a request and held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger sources and prescaler

  logic [3:0] src;
  logic [3:0] src_rise;
  logic [3:0] src_fall;
  logic sel_rise;
  logic sel_fall;
  logic trig_edge;
  logic ext_evt;
  logic tick;

  // index follows the source field: pin, rc clock, receiver 1, receiver 2
  assign src = {second_serial_receive_pin, first_serial_receive_pin,
                lirc_clock, external_input_pin};

  for (genvar i = 0; i < 4; i++) begin : g_src
    trc_edge_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(src[i]),
      .rise(src_rise[i]),
      .fall(src_fall[i])
    );
  end

  assign sel_rise = src_rise[csrc_q];
  assign sel_fall = src_fall[csrc_q];

  // reload and baud modes trigger on the falling edge
  always_comb begin
    unique case (mode)
      trc_pkg::mode_cap_rise: trig_edge = sel_rise;
      trc_pkg::mode_cap_fall: trig_edge = sel_fall;
      trc_pkg::mode_reload: trig_edge = sel_fall;
      trc_pkg::mode_baud: trig_edge = sel_fall;
    endcase
  end

  // every source acts in every mode once software also sets the trigger enable bit
  assign ext_evt = exen & trig_edge;

  trc_prescale #(
    .CNT_W(8)
  ) u_ps (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run),
    .sel(ctl_q[5:4]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter, capture and flags

  logic wrap;
  logic is_cap;
  logic hw_reload;
  logic cap_evt;
  logic ovf_set;
  logic cnt_wr;
  logic baud_q;

  assign wrap = tick & (cnt_q == `TRC_CNT_MAX);
  assign is_cap = (mode == trc_pkg::mode_cap_rise) | (mode == trc_pkg::mode_cap_fall);
  assign hw_reload = (wrap & ~is_cap)
                   | (ext_evt & (mode == trc_pkg::mode_reload));
  assign cap_evt = ext_evt & is_cap;
  assign ovf_set = wrap & (mode != trc_pkg::mode_baud);
  assign cnt_wr = wr_cnt_lo | wr_cnt_hi;

  // software byte writes take priority over counting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `TRC_CNT_RST;
    end else if (wr_cnt_lo) begin
      cnt_q[7:0] <= wd;
    end else if (wr_cnt_hi) begin
      cnt_q[15:8] <= wd;
    end else if (hw_reload) begin
      cnt_q <= rld_q;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // a capture wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rld_q <= `TRC_CNT_RST;
    end else if (cap_evt) begin
      rld_q <= cnt_q;
    end else if (wr_rld_lo) begin
      rld_q[7:0] <= wd;
    end else if (wr_rld_hi) begin
      rld_q[15:8] <= wd;
    end
  end

  // flags: writing 0 clears, writing 1 keeps, a set in the same cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set | (ovf_q & ~(wr_ctl & ~wd[`TRC_CTL_OVF]));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_evt | (ext_q & ~(wr_ctl & ~wd[`TRC_CTL_EXT]));
    end
  end

  // wrap pulse in baud mode is the 16x clock of the second serial port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baud_q <= 1'b0;
    end else begin
      baud_q <= wrap & (mode == trc_pkg::mode_baud);
    end
  end

  assign baud_tick = baud_q;
  assign timer_irq = ie_q & (ovf_q | ext_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  reload_wrap_a: assert property (wrap && mode == trc_pkg::mode_reload && !cnt_wr
    |=> cnt_q == $past(rld_q) && ovf_q) else $error("reload wrap failed");
  ext_reload_a: assert property (ext_evt && mode == trc_pkg::mode_reload && !cnt_wr
    |=> cnt_q == $past(rld_q) && ext_q) else $error("edge reload failed");
  irq_raise_a: assert property ((ovf_set || ext_evt) && ie_q && !wr_ie
    |=> timer_irq) else $error("flag gave no interrupt");
  run_keep_a: assert property ($rose(run) && !cnt_wr && !hw_reload && !wrap
    |=> cnt_q == $past(cnt_q) + 16'($past(tick)))
    else $error("start cleared count");
  baud_wrap_a: assert property (wrap && mode == trc_pkg::mode_baud && !cnt_wr
    |=> cnt_q == $past(rld_q) && baud_tick && !$rose(ovf_q))
    else $error("baud wrap wrong");
  baud_edge_a: assert property (ext_evt && mode == trc_pkg::mode_baud && !wrap && !cnt_wr
    |=> ext_q && (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 16'h0001))
    else $error("baud edge reloaded");
  cap_wrap_a: assert property (wrap && is_cap && !cnt_wr
    |=> cnt_q == 16'h0000 && ovf_q) else $error("capture wrap wrong");
  capture_copy_a: assert property (cap_evt
    |=> rld_q == $past(cnt_q) && ext_q) else $error("capture lost");
  ovf_hold_a: assert property (ovf_q && !(wr_ctl && !wd[`TRC_CTL_OVF])
    |=> ovf_q) else $error("overflow flag dropped");
  ext_quiet_a: assert property (!exen && !ext_q |=> !ext_q)
    else $error("event flag without enable");
  count_step_a: assert property (run && !tick && !cnt_wr && !hw_reload
    |=> cnt_q == $past(cnt_q)) else $error("count moved without tick");
  csrc_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == `TRC_OFS_CSRC
    |-> avs_readdata[7:2] == 6'h00) else $error("reserved bits not zero");
endmodule

// ---- tb/trc_far_end.sv ----
// far-side model: external trigger pin, rc clock and two serial receive lines
`timescale 1ns/10ps
module trc_far_end (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stb,
  input wire logic [1:0] sel,
  input wire logic lvl,
  output logic ext_pin,
  output logic rc_clk,
  output logic rx1,
  output logic rx2
);
  // lines idle high like a receive line; each moves only on request and then stays put
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {ext_pin, rc_clk, rx1, rx2} <= 4'hF;
    end else if (stb) begin
      case (sel)
        2'h0: ext_pin <= lvl;
        2'h1: rc_clk <= lvl;
        2'h2: rx1 <= lvl;
        default: rx2 <= lvl;
      endcase
    end
  end
endmodule

// ---- tb/trc_timer_bench.sv ----
// self-checking bench of the reload/capture timer
`timescale 1ns/10ps
`include "trc_regs.svh"
module trc_timer_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_pin, rc_clk, rx1, rx2, timer_irq, baud_tick;
  logic stb = 1'b0;
  logic [1:0] sel = 2'h0;
  logic lvl = 1'b1;
  logic [7:0] expq[$];
  logic [31:0] seed = 32'h2D;
  logic [31:0] n;
  int fails = 0;
  int comparisons = 0;
  int dv[4] = '{1, 8, 64, 256};
  always #10 mclk = ~mclk;
  trc_timer #(.ADDR_W(5)) DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_input_pin(ext_pin), .lirc_clock(rc_clk), .first_serial_receive_pin(rx1),
    .second_serial_receive_pin(rx2), .timer_irq(timer_irq), .baud_tick(baud_tick));
  trc_far_end far (.mclk(mclk), .rst_n(rst_n), .stb(stb), .sel(sel), .lvl(lvl),
    .ext_pin(ext_pin), .rc_clk(rc_clk), .rx1(rx1), .rx2(rx2));
  ////////////////////////////////////////
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] ctl(input logic [1:0] f, input logic [1:0] ps, input logic [1:0] m,
                           input logic run, input logic ex);
    return {f, ps, m, run, ex};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one bus cycle held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    if (wr) begin
      avs_write <= 1'b1;
    end else begin
      avs_read <= 1'b1;
      expq.push_back(d);
    end
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, e);
  endtask
  // move one far-side line, then let the synchroniser and flag update land
  task pin(input logic [1:0] s, input logic v);
    @(posedge mclk);
    sel <= s;
    lvl <= v;
    stb <= 1'b1;
    @(posedge mclk);
    stb <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task tick_gap();
    n = 0;
    do begin
      @(posedge mclk);
      n = n + 1;
    end while (baud_tick !== 1'b1 && n < 9000);
  endtask
  // read results are compared in the order they were requested
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check(avs_readdata, {24'h000000, expq.pop_front()});
    end
  end
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] v;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), 8'h00);
    end
    for (int i = 2; i < 6; i++) begin
      v = xs();
      wr(5'(i * 4), v);
      rd(5'(i * 4), v);
    end
    wr(`TRC_OFS_CSRC, 8'hFF);
    rd(`TRC_OFS_CSRC, 8'h03);
    wr(`TRC_OFS_CSRC, 8'h00);
    wr(`TRC_OFS_IE, 8'h01);
    // reload mode wrap from a preset count
    wr(`TRC_OFS_RLD_HI, 8'h12);
    wr(`TRC_OFS_RLD_LO, 8'h00);
    wr(`TRC_OFS_CNT_HI, 8'hFF);
    wr(`TRC_OFS_CNT_LO, 8'hFE);
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h0, 1'b1, 1'b0));
    wr(`TRC_OFS_CTRL, ctl(2'h2, 2'h0, 2'h0, 1'b0, 1'b0));
    rd(`TRC_OFS_CNT_HI, 8'h12);
    rd(`TRC_OFS_CTRL, 8'h80);
    check(timer_irq, 1'b1);
    wr(`TRC_OFS_CTRL, 8'h00);
    rd(`TRC_OFS_CTRL, 8'h00);
    check(timer_irq, 1'b0);
    // capture mode runs free through the wrap
    wr(`TRC_OFS_CNT_HI, 8'hFF);
    wr(`TRC_OFS_CNT_LO, 8'hFE);
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h0, 2'h2, 1'b1, 1'b0));
    wr(`TRC_OFS_CTRL, ctl(2'h3, 2'h0, 2'h2, 1'b0, 1'b0));
    rd(`TRC_OFS_CNT_HI, 8'h00);
    rd(`TRC_OFS_CTRL, 8'h88);
    rd(`TRC_OFS_RLD_HI, 8'h12);
    // every capture source, wrong edge first
    for (int s = 0; s < 4; s++) begin
      wr(`TRC_OFS_CSRC, 8'(s));
      wr(`TRC_OFS_CNT_HI, 8'(8'hA0 + s));
      wr(`TRC_OFS_CNT_LO, 8'h00);
      wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h2, 1'b1, 1'b1));
      pin(2'(s), 1'b0);
      rd(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h2, 1'b1, 1'b1));
      pin(2'(s), 1'b1);
      rd(`TRC_OFS_RLD_HI, 8'(8'hA0 + s));
      rd(`TRC_OFS_CTRL, ctl(2'h1, 2'h3, 2'h2, 1'b1, 1'b1));
      check(timer_irq, 1'b1);
      wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h2, 1'b0, 1'b0));
    end
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h3, 1'b1, 1'b1));
    pin(2'h3, 1'b0);
    rd(`TRC_OFS_RLD_HI, 8'hA3);
    rd(`TRC_OFS_CTRL, ctl(2'h1, 2'h3, 2'h3, 1'b1, 1'b1));
    pin(2'h3, 1'b1);
    // trigger disabled: edges change nothing
    wr(`TRC_OFS_CSRC, 8'h00);
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h2, 1'b1, 1'b0));
    pin(2'h0, 1'b0);
    pin(2'h0, 1'b1);
    rd(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h2, 1'b1, 1'b0));
    rd(`TRC_OFS_RLD_HI, 8'hA3);
    // reload mode edge reload, then baud mode edge without reload
    wr(`TRC_OFS_RLD_HI, 8'h77);
    wr(`TRC_OFS_RLD_LO, 8'h00);
    wr(`TRC_OFS_CNT_HI, 8'h55);
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h0, 1'b1, 1'b1));
    pin(2'h0, 1'b0);
    rd(`TRC_OFS_CNT_HI, 8'h77);
    rd(`TRC_OFS_CTRL, ctl(2'h1, 2'h3, 2'h0, 1'b1, 1'b1));
    pin(2'h0, 1'b1);
    wr(`TRC_OFS_CNT_HI, 8'h55);
    wr(`TRC_OFS_CNT_LO, 8'h00);
    wr(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h1, 1'b1, 1'b1));
    pin(2'h0, 1'b0);
    rd(`TRC_OFS_CNT_HI, 8'h55);
    rd(`TRC_OFS_CTRL, ctl(2'h1, 2'h3, 2'h1, 1'b1, 1'b1));
    pin(2'h0, 1'b1);
    // baud tick spacing for each prescale choice
    wr(`TRC_OFS_RLD_HI, 8'hFF);
    wr(`TRC_OFS_RLD_LO, 8'hF0);
    wr(`TRC_OFS_CNT_HI, 8'hFF);
    wr(`TRC_OFS_CNT_LO, 8'hF0);
    for (int p = 0; p < 4; p++) begin
      wr(`TRC_OFS_CTRL, ctl(2'h0, 2'(p), 2'h1, 1'b1, 1'b0));
      tick_gap();
      tick_gap();
      check(n, 32'(16 * dv[p]));
    end
    rd(`TRC_OFS_CTRL, ctl(2'h0, 2'h3, 2'h1, 1'b1, 1'b0));
    check(timer_irq, 1'b0);
    tally_and_finish();
  end
endmodule
